/* File: common/count_snap_pkg.sv */
package count_snap_pkg;

  localparam int CNT_WIDTH = 8;
  localparam logic [7:0] COUNT_RESET_VALUE = 8'h00;
  localparam logic [7:0] RELOAD_DEFAULT = 8'hFF;
  localparam int FILTER_TIME_NS = 10;
  localparam int CLK_PERIOD_NS = 20;
  // longest glitch suppressed, rounded down, at least one cycle
  localparam int FILTER_CYCLES_RAW = FILTER_TIME_NS / CLK_PERIOD_NS;
  localparam int FILTER_CYCLES = (FILTER_CYCLES_RAW < 1) ? 1 : FILTER_CYCLES_RAW;
  localparam logic [1:0] CLK_SEL_OSC = 2'h0;
  localparam logic [1:0] CLK_SEL_MATRIX = 2'h1;
  localparam logic [1:0] CLK_SEL_EXT = 2'h2;

  typedef enum logic [2:0] {
    SNAP_IDLE = 3'h1,
    SNAP_WAIT = 3'h2,
    SNAP_DONE = 3'h4
  } snap_state_e;

  typedef struct packed {
    logic [1:0] clkSel;
    logic       countDown;
    logic [7:0] reload;
  } cnt_cfg_s;

  typedef struct packed {
    logic       readReq;
    logic       readAck;
    logic [7:0] readData;
  } snap_port_s;

endpackage

/* File: rtl/counter_count_snapshot_read.sv */
module counter_count_snapshot_read
  import count_snap_pkg::*;
#(
  parameter int FILTER_LEN = FILTER_CYCLES
)(
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire cnt_cfg_s   cfg,
  input  wire logic       oscTick,
  input  wire logic       matrixClk,
  input  wire logic       matrixDriven,
  input  wire logic       cntResetIn,
  input  wire logic       readReq,
  input  wire logic       filterIn,
  output logic            readAck,
  output logic [7:0]      readData,
  output logic [7:0]      countOut,
  output logic            cntEvent,
  output logic            filterOut
);

  // filter run length at counter width
  localparam logic [7:0] FILTER_LIMIT = 8'(FILTER_LEN);

  // every piece of state in one record
  typedef struct packed {
    logic [7:0]  count;
    logic [7:0]  snap;
    logic        ack;
    logic        evt;
    snap_state_e st;
    logic [1:0]  rstSync;
    logic        matrixPrev;
    logic        filtState;
    logic [7:0]  filtCnt;
  } state_s;

  // current and next state
  state_s stReg;
  state_s stNext;

  // counter, snapshot, reset sync, and filter next-state
  always_comb
  begin
    logic       clkEdge;
    logic       rstCnt;
    logic       matrixLevel;
    logic [7:0] cntDec;
    logic [7:0] cntInc;
    logic       atFloor;
    logic       atTop;
    clkEdge     = 1'b0;
    rstCnt      = 1'b0;
    matrixLevel = 1'b0;
    cntDec      = 8'h00;
    cntInc      = 8'h00;
    atFloor     = 1'b0;
    atTop       = 1'b0;
    stNext      = stReg;

    // strobes default low; ack one cycle wide, evt high for each cycle that wraps, so back to back when wraps follow
    stNext.ack = 1'b0;
    stNext.evt = 1'b0;

    // two-stage reset synchroniser ahead of the count logic
    stNext.rstSync = {stReg.rstSync[0], cntResetIn};
    rstCnt = stReg.rstSync[1];

    // undriven matrix source reads as ground
    matrixLevel = matrixClk & matrixDriven;
    stNext.matrixPrev = matrixLevel;

    // count-edge source select
    if (cfg.clkSel == CLK_SEL_OSC)
    begin
      clkEdge = oscTick;
    end
    else if (cfg.clkSel == CLK_SEL_MATRIX)
    begin
      clkEdge = matrixLevel & ~stReg.matrixPrev;
    end
    else
    begin
      clkEdge = 1'b0;
    end

    // neighbour values and terminal tests
    cntDec  = stReg.count - 8'h01;
    cntInc  = stReg.count + 8'h01;
    atFloor = (stReg.count == 8'h00);
    atTop   = (stReg.count == cfg.reload);

    // reset dominates any edge in the same cycle, reload is clean
    if (rstCnt)
    begin
      stNext.count = cfg.reload;
    end
    // no edge, no change: a stopped clock only stretches the period
    else if (clkEdge)
    begin
      if (cfg.countDown)
      begin
        // down: floor wraps to reload with an event
        if (atFloor)
        begin
          stNext.count = cfg.reload;
          stNext.evt   = 1'b1;
        end
        else
        begin
          stNext.count = cntDec;
        end
      end
      else
      begin
        // up: reload wraps to zero with an event
        if (atTop)
        begin
          stNext.count = 8'h00;
          stNext.evt   = 1'b1;
        end
        else
        begin
          stNext.count = cntInc;
        end
      end
    end

    // snapshot sequence: copy from registered count only
    case (stReg.st)
      SNAP_IDLE:
      begin
        if (readReq)
        begin
          stNext.st = SNAP_WAIT;
        end
      end
      SNAP_WAIT:
      begin
        // count is one register, so all bits share one state
        stNext.snap = stReg.count;
        stNext.ack  = 1'b1;
        stNext.st   = SNAP_DONE;
      end
      SNAP_DONE:
      begin
        if (!readReq)
        begin
          stNext.st = SNAP_IDLE;
        end
      end
      default:
      begin
        // recover from an illegal code
        stNext.st = SNAP_IDLE;
      end
    endcase

    // glitch filter: output follows input only after a stable run
    if (filterIn == stReg.filtState)
    begin
      // input agrees, restart the run
      stNext.filtCnt = 8'h00;
    end
    // run long enough, take the new level
    else if (stReg.filtCnt >= FILTER_LIMIT)
    begin
      stNext.filtState = filterIn;
      stNext.filtCnt   = 8'h00;
    end
    else
    begin
      stNext.filtCnt = stReg.filtCnt + 8'h01;
    end
  end

  // state register
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      // every field to its idle value
      stReg.count      <= COUNT_RESET_VALUE;
      stReg.snap       <= 8'h00;
      stReg.ack        <= 1'b0;
      stReg.evt        <= 1'b0;
      stReg.st         <= SNAP_IDLE;
      stReg.rstSync    <= 2'h0;
      stReg.matrixPrev <= 1'b0;
      stReg.filtState  <= 1'b0;
      stReg.filtCnt    <= 8'h00;
    end
    else
    begin
      stReg <= stNext;
    end
  end

  // outputs straight from the state register
  assign readAck   = stReg.ack;
  assign readData  = stReg.snap;
  assign countOut  = stReg.count;
  assign cntEvent  = stReg.evt;
  assign filterOut = stReg.filtState;

endmodule

/* File: verif/count_snap_sva.sv */
module count_snap_sva
  import count_snap_pkg::*;
(
  input logic       sys_clk,
  input logic       rst_n,
  input cnt_cfg_s   cfg,
  input logic       oscTick,
  input logic       cntResetIn,
  input logic       readAck,
  input logic [7:0] readData,
  input logic [7:0] countOut,
  input logic       filterIn,
  input logic       filterOut
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // down-count edge
  wire tick = !cfg.clkSel && cfg.countDown && oscTick;
  property p_ack; readAck |=> !readAck; endproperty
  a_ack: assert property (p_ack) else $error("ack");
  property p_snap; readAck |-> readData == $past(countOut); endproperty
  a_snap: assert property (p_snap) else $error("snap");
  property p_dec; tick && |countOut && !$past(cntResetIn, 2) |=> countOut == $past(countOut) - 8'h01; endproperty
  a_dec: assert property (p_dec) else $error("dec");
  property p_wrap; tick && !countOut && !$past(cntResetIn, 2) |=> countOut == $past(cfg.reload); endproperty
  a_wrap: assert property (p_wrap) else $error("wrap");
  property p_gnd; !cntResetIn [*4] ##0 cfg.clkSel[1] |=> $stable(countOut); endproperty
  a_gnd: assert property (p_gnd) else $error("gnd");
  property p_rst; $rose(cntResetIn) |-> ##[3:4] countOut == cfg.reload; endproperty
  a_rst: assert property (p_rst) else $error("rst");
  property p_glitch; !filterOut && $rose(filterIn) ##1 !filterIn |-> !filterOut [*3]; endproperty
  a_glitch: assert property (p_glitch) else $error("glitch");
  property p_pass; filterIn [*4] |-> filterOut; endproperty
  a_pass: assert property (p_pass) else $error("pass");
endmodule

/* File: verif/host_reader.sv */
module host_reader (
  input  logic       sys_clk,
  input  logic       go,
  input  logic       readAck,
  input  logic [7:0] readData,
  output logic       readReq = 1'b0,
  output logic [7:0] got
);
  timeunit 1ns;
  timeprecision 1ns;
  // request held until ack, data taken there
  always @(posedge sys_clk)
    if (readAck)
    begin
      readReq <= 1'b0;
      got     <= readData;
    end
    else if (go)
      readReq <= 1'b1;
endmodule

/* File: verif/test_counter_count_snapshot_read.sv */
module test_counter_count_snapshot_read
  import count_snap_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic       sys_clk = 0, rst_n = 0, oscTick = 0, cntResetIn = 0, filterIn = 0, go = 0;
  logic       matrixClk = 0, matrixDriven = 0, readReq, readAck, cntEvent, filterOut;
  logic [7:0] readData, countOut, got, e = 8'h00, eSnap = 8'h00;
  logic       mPrev = 0, mNow = 0, tk = 0;
  logic [1:0] rsPipe = 2'h0;
  cnt_cfg_s   cfg = '{2'h2, 1'b1, 8'h00};
  int         bad_count = 0, total_checks = 0;
  int         evExp = 0, evSeen = 0, evBase = 0;
  counter_count_snapshot_read u_counter_count_snapshot_read (.*);
  host_reader u_host_reader (.*);
  // event pulses counted away from the launching edge
  always @(negedge sys_clk)
    if (cntEvent === 1'b1)
      evSeen++;
  // compare and count
  task automatic check(logic [7:0] s, logic [7:0] w);
    total_checks++;
    bad_count += s !== w;
    if (s !== w)
      $display("unexpected at %0t: %h not %h", $time, s, w);
  endtask
  // counts and verdict
  task automatic give_verdict(int late);
    bad_count += late;
    $display("%0d checks, %0d bad", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial forever #10 sys_clk = ~sys_clk;
  initial #60us give_verdict(1);
  // rounds: counter reset, count with a read, stop, read
  initial
  begin
    void'($urandom(14746));
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 12; i++)
    begin
      cfg.reload    <= i < 3 ? 8'(i) : 8'($urandom);
      cfg.countDown <= i % 3 != 1;
      evBase = evSeen;
      evExp  = 0;
      for (int k = 0; k < 64; k++)
      begin
        cntResetIn   <= k < 6 || (i == 6 && k == 30);
        oscTick      <= 1'($urandom);
        matrixClk    <= 1'($urandom) & (k < 50);
        matrixDriven <= i % 4 != 3;
        filterIn     <= k % 7 == 3 || k > 40;
        go           <= k == 12 || k == 52;
        cfg.clkSel   <= k < 10 ? CLK_SEL_EXT : i % 2 ? CLK_SEL_MATRIX : k < 50 ? CLK_SEL_OSC : CLK_SEL_EXT;
        @(posedge sys_clk);
        mNow  = matrixClk & matrixDriven;
        tk    = cfg.clkSel == CLK_SEL_OSC ? oscTick : cfg.clkSel == CLK_SEL_MATRIX ? mNow & ~mPrev : 1'b0;
        mPrev = mNow;
        if (rsPipe[1])
          e = cfg.reload;
        else if (tk && cfg.countDown)
        begin
          evExp += e == 8'h00;
          e = e == 8'h00 ? cfg.reload : e - 8'h01;
        end
        else if (tk)
        begin
          evExp += e == cfg.reload;
          e = e == cfg.reload ? 8'h00 : e + 8'h01;
        end
        rsPipe = {rsPipe[0], cntResetIn};
        if (k == 13)
          eSnap = e;
        if (k == 20)
          check(got, eSnap);
      end
      check(got, e);
      check(countOut, e);
      check(8'(filterOut), 8'h01);
      check(8'(evSeen - evBase), 8'(evExp));
      $display("round %0d", i);
    end
    give_verdict(0);
  end
endmodule
bind counter_count_snapshot_read count_snap_sva u_count_snap_sva (.*);
